// File: rwps_seq.sv
// Purpose: RAM playback address sequencer with AXI4-Lite register access
// Assumes: Single clock; profile pins and update strobe arrive asynchronously
// Notes:   RAM words come back one cycle after the address is presented
`timescale 1ns/1ps
`default_nettype none
module rwps_seq #(
    parameter int ADDR_W = rwps_pkg::ADDR_W,
    parameter int RATE_W = rwps_pkg::RATE_W
) (
    input  wire logic               clk,
    input  wire logic               rst,
    // AXI4-Lite slave
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // Pins
    input  wire logic [2:0]         profile_pins,
    input  wire logic               io_update,
    output logic                    sweep_over_flag,
    // RAM side
    output logic [ADDR_W-1:0]       ram_addr,
    input  wire logic [31:0]        ram_rdata,
    output rwps_pkg::rwps_out_t     synth_out
);
    if (ADDR_W != rwps_pkg::ADDR_W || RATE_W != rwps_pkg::RATE_W) begin : g_width_chk
        $error("rwps_seq: widths must match the package field layout");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DWELL} rwps_state_t;

    // Registers
    logic [31:0] ctrl1_q;
    logic [3:0]  dest_q;
    logic [31:0] prof_a_q [rwps_pkg::NUM_PROF];
    logic [31:0] prof_b_q [rwps_pkg::NUM_PROF];

    function automatic rwps_pkg::rwps_prof_t get_prof(input logic [2:0] idx);
        rwps_pkg::rwps_prof_t p;
        p.start_addr = prof_a_q[idx][rwps_pkg::START_LSB +: ADDR_W];
        p.end_addr   = prof_a_q[idx][rwps_pkg::END_LSB +: ADDR_W];
        p.rate       = prof_b_q[idx][rwps_pkg::RATE_LSB +: RATE_W];
        p.mode       = rwps_pkg::rwps_mode_t'(prof_b_q[idx][rwps_pkg::MODE_LSB +: 3]);
        return p;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // Pin synchronisers: three stages, change counts when stages two and three agree
    logic [2:0] prof_s1_q, prof_s2_q, prof_s3_q, prof_q;
    logic       upd_s1_q, upd_s2_q, upd_s3_q, upd_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            prof_s1_q <= 3'h0;
            prof_s2_q <= 3'h0;
            prof_s3_q <= 3'h0;
            prof_q    <= 3'h0;
            upd_s1_q  <= 1'b0;
            upd_s2_q  <= 1'b0;
            upd_s3_q  <= 1'b0;
            upd_q     <= 1'b0;
        end else begin
            prof_s1_q <= profile_pins;
            prof_s2_q <= prof_s1_q;
            prof_s3_q <= prof_s2_q;
            upd_s1_q  <= io_update;
            upd_s2_q  <= upd_s1_q;
            upd_s3_q  <= upd_s2_q;
            for (int i = 0; i < 3; i++) begin
                if (prof_s2_q[i] == prof_s3_q[i]) prof_q[i] <= prof_s3_q[i];
            end
            if (upd_s2_q == upd_s3_q) upd_q <= upd_s3_q;
        end
    end

    // Filtered pin values, one cycle delayed copy for edge detection
    logic [2:0] prof_d1_q;
    logic       upd_d1_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            prof_d1_q <= 3'h0;
            upd_d1_q  <= 1'b0;
        end else begin
            prof_d1_q <= prof_q;
            upd_d1_q  <= upd_q;
        end
    end

    // AXI4-Lite write path: address and data accepted in either order
    logic        aw_hold_q, w_hold_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign s_axi_bresp   = 2'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register storage; unmapped writes are dropped with OKAY
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_q <= rwps_pkg::CTRL1_RST;
            dest_q  <= rwps_pkg::DEST_RST;
            for (int i = 0; i < rwps_pkg::NUM_PROF; i++) begin
                prof_a_q[i] <= rwps_pkg::PROFA_RST;
                prof_b_q[i] <= rwps_pkg::PROFB_RST;
            end
        end else if (wr_fire) begin
            if (aw_addr_q[7:2] == rwps_pkg::REG_CTRL1[7:2])
                ctrl1_q <= merge(ctrl1_q, w_data_q, w_strb_q);
            if (aw_addr_q[7:2] == rwps_pkg::REG_DEST[7:2] && w_strb_q[0])
                dest_q <= w_data_q[3:0];
            if (aw_addr_q[7:6] == 2'h0 && aw_addr_q[5]) begin
                if (aw_addr_q[2])
                    prof_b_q[aw_addr_q[4:3]] <= merge(prof_b_q[aw_addr_q[4:3]], w_data_q, w_strb_q);
                else
                    prof_a_q[aw_addr_q[4:3]] <= merge(prof_a_q[aw_addr_q[4:3]], w_data_q, w_strb_q);
            end
        end
    end

    // Sequencer state (declared here so status readback can see it)
    rwps_state_t        st_q;
    logic [ADDR_W-1:0]  addr_q;
    logic [RATE_W-1:0]  tmr_q;
    logic [2:0]         act_q;
    logic               dir_up_q;
    logic [1:0]         pulse_q;
    logic               flag_q;
    logic               rearm_q;

    // AXI4-Lite read path: one-cycle answer, unmapped reads return zero
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = 2'h0;
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[7:2] == rwps_pkg::REG_CTRL1[7:2])
                s_axi_rdata <= ctrl1_q;
            else if (s_axi_araddr[7:2] == rwps_pkg::REG_STATUS[7:2])
                s_axi_rdata <= {12'h000, 2'(st_q), act_q, dir_up_q, sweep_over_flag,
                                3'h0, 6'(addr_q), 4'h0};
            else if (s_axi_araddr[7:2] == rwps_pkg::REG_DEST[7:2])
                s_axi_rdata <= {28'h0000000, dest_q};
            else if (s_axi_araddr[7:6] == 2'h0 && s_axi_araddr[5])
                s_axi_rdata <= s_axi_araddr[2] ? prof_b_q[s_axi_araddr[4:3]]
                                               : prof_a_q[s_axi_araddr[4:3]];
            else
                s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Playback control
    logic [3:0]           auto_f;
    logic                 auto_on, auto_cont;
    logic [2:0]           auto_last;
    logic                 upd_evt, pin_chg, p0_chg, restart;
    rwps_pkg::rwps_prof_t cur, p0;
    rwps_pkg::rwps_mode_t mode_act;
    logic                 expire, at_end, at_start;
    logic                 bidir_lock;

    assign auto_f     = ctrl1_q[rwps_pkg::AUTO_MSB:rwps_pkg::AUTO_LSB];
    assign auto_on    = auto_f != 4'h0 && auto_f != 4'hF;
    assign auto_cont  = auto_f[3];
    assign auto_last  = auto_f[2:0] + 3'(auto_cont);                          // Last profile index
    assign upd_evt    = upd_q && !upd_d1_q;
    always_comb begin
        p0       = get_prof(3'h0);
        cur      = get_prof(act_q);
        mode_act = cur.mode;
    end
    assign bidir_lock = mode_act == rwps_pkg::RWPS_MODE_BIDIR && !auto_on;
    assign pin_chg    = prof_q[2:1] != prof_d1_q[2:1] || prof_q[0] != prof_d1_q[0];
    assign p0_chg     = prof_q[0] != prof_d1_q[0];
    // Pin changes restart playback, except in the locked bidirectional profile or in auto mode
    assign restart    = upd_evt || (pin_chg && !bidir_lock && !auto_on);
    assign expire     = tmr_q == 16'h0000;
    assign at_end     = addr_q == cur.end_addr;
    assign at_start   = addr_q == cur.start_addr;

    // Profile 0 rules bidirectional mode whatever the pins say
    function automatic logic [2:0] entry_prof();
        if (auto_on || p0.mode == rwps_pkg::RWPS_MODE_BIDIR) return 3'h0;
        return prof_q;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q     <= ST_IDLE;
            addr_q   <= '0;
            tmr_q    <= '0;
            act_q    <= 3'h0;
            dir_up_q <= 1'b1;
            flag_q   <= 1'b0;
            pulse_q  <= 2'h0;
            rearm_q  <= 1'b0;
        end else begin
            pulse_q <= pulse_q - 2'(pulse_q != 2'h0 ? 1 : 0);
            if (restart) begin
                act_q    <= entry_prof();
                addr_q   <= get_prof(entry_prof()).start_addr;
                tmr_q    <= get_prof(entry_prof()).rate;
                dir_up_q <= 1'b1;
                flag_q   <= 1'b0;
                pulse_q  <= 2'h0;
                rearm_q  <= 1'b0;
                st_q     <= (!auto_on && p0.mode == rwps_pkg::RWPS_MODE_BIDIR)
                            ? ST_IDLE : ST_RUN;
            end else if (!auto_on && mode_act == rwps_pkg::RWPS_MODE_BIDIR) begin
                // No-dwell has no effect here by construction
                if (p0_chg) begin
                    dir_up_q <= prof_q[0];
                    tmr_q    <= cur.rate;
                    st_q     <= ST_RUN;
                    if (prof_q[0] && rearm_q) flag_q <= 1'b0;
                    rearm_q  <= 1'b0;
                end else if (st_q == ST_RUN) begin
                    if (dir_up_q && at_end) begin
                        st_q   <= ST_DWELL;
                        flag_q <= 1'b1;
                    end else if (!dir_up_q && at_start) begin
                        st_q    <= ST_DWELL;
                        rearm_q <= flag_q;
                    end else if (expire) begin
                        tmr_q  <= cur.rate;
                        addr_q <= dir_up_q ? addr_q + 1'b1 : addr_q - 1'b1;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
            end else if (st_q == ST_RUN) begin
                if (expire) begin
                    tmr_q <= cur.rate;
                    if (mode_act == rwps_pkg::RWPS_MODE_CBIDIR && !auto_on) begin
                        if ((dir_up_q && at_end) || (!dir_up_q && at_start)) begin
                            dir_up_q <= !dir_up_q;
                            addr_q   <= dir_up_q ? addr_q - 1'b1 : addr_q + 1'b1;
                        end else begin
                            addr_q <= dir_up_q ? addr_q + 1'b1 : addr_q - 1'b1;
                        end
                        if (dir_up_q && addr_q + 1'b1 == cur.end_addr)
                            flag_q <= 1'b1;
                        if (!dir_up_q && addr_q - 1'b1 == cur.start_addr)
                            flag_q <= 1'b0;
                    end else if (at_end) begin
                        if (auto_on) begin
                            if (act_q == auto_last && !auto_cont) begin
                                st_q <= ST_DWELL;                // burst halts
                            end else begin
                                act_q  <= (act_q == auto_last) ? 3'h0
                                                               : act_q + 3'h1;
                                addr_q <= get_prof((act_q == auto_last) ? 3'h0
                                                               : act_q + 3'h1).start_addr;
                                tmr_q  <= get_prof((act_q == auto_last) ? 3'h0
                                                               : act_q + 3'h1).rate;
                            end
                        end else if (mode_act == rwps_pkg::RWPS_MODE_RECIRC) begin
                            addr_q <= cur.start_addr;
                        end else begin
                            st_q <= ST_DWELL;
                        end
                    end else begin
                        addr_q <= addr_q + 1'b1;
                        if (addr_q + 1'b1 == cur.end_addr &&
                            (auto_on || mode_act == rwps_pkg::RWPS_MODE_RECIRC))
                            pulse_q <= 2'(rwps_pkg::SWEEP_PULSE_CYC);
                    end
                end else begin
                    tmr_q <= tmr_q - 1'b1;
                end
            end
        end
    end

    // Recirculate and auto modes use the pulse, the two bidirectional modes the level
    always_ff @(posedge clk) begin
        if (rst) sweep_over_flag <= 1'b0;
        else     sweep_over_flag <= flag_q || pulse_q != 2'h0;
    end
    assign ram_addr = addr_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            synth_out <= '0;
        end else begin
            synth_out.word <= ram_rdata;
            synth_out.dest <= dest_q;
        end
    end

endmodule // rwps_seq
`default_nettype wire

// File: rwps_pkg.sv
// Purpose: Shared constants and types for the RAM waveform playback sequencer
// Assumes: 32-bit AXI4-Lite register bus, 125 MHz clock
// Notes:   Profile fields are packed into two registers per profile
package rwps_pkg;

    localparam int ADDR_W      = 10;
    localparam int RATE_W      = 16;
    localparam int NUM_PROF    = 8;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL1    = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_DEST     = 8'h08;
    localparam logic [7:0] REG_PROF_A   = 8'h20;  // Profile n (0 to 3) start/end at 0x20 + 8n
    localparam logic [7:0] REG_PROF_B   = 8'h24;  // Profile n (0 to 3) rate/mode at 0x24 + 8n

    // Control register one fields
    localparam int AUTO_LSB     = 17;
    localparam int AUTO_MSB     = 20;
    localparam int NODWELL_BIT  = 0;

    // Profile word A fields
    localparam int START_LSB    = 0;
    localparam int END_LSB      = 16;
    // Profile word B fields
    localparam int RATE_LSB     = 0;
    localparam int MODE_LSB     = 16;

    localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
    localparam logic [31:0] PROFA_RST = 32'h0000_0000;
    localparam logic [31:0] PROFB_RST = 32'h0000_0001;
    localparam logic [3:0]  DEST_RST  = 4'h1;

    // Sweep flag pulse length in clock cycles
    localparam int SWEEP_PULSE_CYC = 2;

    typedef enum logic [2:0] {
        RWPS_MODE_DIRECT  = 3'h0,
        RWPS_MODE_RAMPUP  = 3'h1,
        RWPS_MODE_BIDIR   = 3'h2,
        RWPS_MODE_CBIDIR  = 3'h3,
        RWPS_MODE_RECIRC  = 3'h4
    } rwps_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] start_addr;
        logic [ADDR_W-1:0] end_addr;
        logic [RATE_W-1:0] rate;
        rwps_mode_t        mode;
    } rwps_prof_t;

    typedef struct packed {
        logic [31:0] word;
        logic [3:0]  dest;
    } rwps_out_t;

endpackage

// File: rwps_seq_chk.sv
// Purpose: Port-level checks on the playback sequencer
// Assumes: One clock, synchronous active-high reset
// Notes:   Mode is not visible here, so flag pulses are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module rwps_seq_chk (
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire logic                sweep_over_flag,
    input wire logic [9:0]          ram_addr,
    input wire logic [31:0]         ram_rdata,
    input wire rwps_pkg::rwps_out_t synth_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response not held");
    AST_B_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
    AST_ROUTE: assert property (!$past(rst) |-> synth_out.word == $past(ram_rdata))
        else $error("ram word not passed to synthesis");
    AST_RST_IDLE: assert property ($fell(rst) |-> !sweep_over_flag && ram_addr == 10'h000)
        else $error("sequencer not idle after reset");
    COV_FLAG_UP: cover property ($rose(sweep_over_flag));
    COV_FLAG_DN: cover property ($fell(sweep_over_flag));
    COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
endmodule // rwps_seq_chk
bind rwps_seq rwps_seq_chk i_chk (.clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sweep_over_flag(sweep_over_flag), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .synth_out(synth_out));
`default_nettype wire

// File: rwps_ctl_model.sv
// Purpose: External controller on the profile pins and update strobe, plus RAM
// Assumes: Block synchronises pins; strobe held long enough to pass it
// Notes:   RAM word carries its address so routing can be checked
`timescale 1ns/1ps
`default_nettype none
module rwps_ctl_model (
    input  wire logic        clk,
    input  wire logic [9:0]  ram_addr,
    output logic [2:0]       profile_pins,
    output logic             io_update,
    output logic [31:0]      ram_rdata
);
    initial begin
        profile_pins = 3'h0;
        io_update    = 1'b0;
        ram_rdata    = 32'h0;
    end
    // Synchronous RAM: one cycle from address to word
    always @(posedge clk) begin
        ram_rdata <= {22'h0A5A5A, ram_addr};
    end
    task automatic set_pins(input logic [2:0] v);
        @(posedge clk);
        profile_pins <= v;
    endtask
    // Held several cycles so the block's synchroniser sees a clean edge
    task automatic strobe();
        @(posedge clk);
        io_update <= 1'b1;
        repeat (5) @(posedge clk);
        io_update <= 1'b0;
    endtask
endmodule // rwps_ctl_model
`default_nettype wire

// File: rwps_seq_tb.sv
// Purpose: Self-checking bench for the playback sequencer
// Assumes: Step takes rate+1 cycles; flag pulse follows end by one cycle
// Notes:   Register access over AXI4-Lite tasks
`timescale 1ns/1ps
`default_nettype none
module rwps_seq_tb;
    logic clk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] strb;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, io_update, sweep_over_flag;
    logic [1:0] bresp, rresp;
    logic [2:0] profile_pins;
    logic [9:0] ram_addr;
    logic [31:0] ram_rdata;
    rwps_pkg::rwps_out_t synth_out;
    int err_total = 0, comparisons = 0, gap = 0;
    always #4 clk = ~clk;
    rwps_seq i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .profile_pins(profile_pins), .io_update(io_update),
        .sweep_over_flag(sweep_over_flag), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
        .synth_out(synth_out));
    rwps_ctl_model i_ctl (.clk(clk), .ram_addr(ram_addr), .profile_pins(profile_pins),
        .io_update(io_update), .ram_rdata(ram_rdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Ready comes a cycle late so the held-answer case is exercised
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= !bready;
        end while (awvalid || wvalid || !(bvalid && bready));
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) rd = rdata;
            if (rvalid) rready <= !rready;
        end while (arvalid || !(rvalid && rready));
        chk(rd, exp);
        chk(32'(rresp), 32'h0);
    endtask
    task automatic prof(input int n, input logic [9:0] s, e, input logic [15:0] r,
                        input rwps_pkg::rwps_mode_t m);
        axi_wr(rwps_pkg::REG_PROF_A + 8'(8 * n), {6'h0, e, 6'h0, s});
        axi_wr(rwps_pkg::REG_PROF_B + 8'(8 * n), {13'h0, m, r});
    endtask
    task automatic wait_addr(input logic [9:0] a);
        int n;
        n = 0;
        while (ram_addr !== a && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(32'(ram_addr), 32'(a));
    endtask
    // gap ends up as the cycles from the previous address change
    task automatic next_addr(input logic [9:0] a);
        logic [9:0] last;
        last = ram_addr;
        gap = 0;
        while (ram_addr === last && gap < 400) begin
            @(posedge clk);
            gap++;
        end
        chk(32'(ram_addr), 32'(a));
    endtask
    task automatic flag_cycles(input int exp);
        int n;
        n = 0;
        repeat (6) begin
            @(posedge clk);
            if (sweep_over_flag === 1'b1) n++;
        end
        chk(32'(n), 32'(exp));
    endtask
    task automatic hold_chk(input logic [9:0] a, input logic f);
        repeat (24) @(posedge clk);
        chk(32'(ram_addr), 32'(a));
        chk(32'(sweep_over_flag), 32'(f));
    endtask
    initial begin
        awaddr <= 8'h00;
        araddr <= 8'h00;
        wdata <= 32'h0000_0000;
        strb <= 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(rwps_pkg::REG_CTRL1, rwps_pkg::CTRL1_RST);
        rd_chk(rwps_pkg::REG_PROF_B, rwps_pkg::PROFB_RST);
        rd_chk(rwps_pkg::REG_DEST, 32'(rwps_pkg::DEST_RST));
        axi_wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h0);
        // Only byte one may land
        strb <= 4'h2;
        axi_wr(rwps_pkg::REG_CTRL1, 32'hFFFF_FFFF);
        strb <= 4'hF;
        rd_chk(rwps_pkg::REG_CTRL1, 32'h0000_FF00);
        // Automatic continuous sequencing over profiles 0 and 1
        prof(0, 10'h004, 10'h005, 16'h0007, rwps_pkg::RWPS_MODE_RECIRC);
        prof(1, 10'h008, 10'h009, 16'h0007, rwps_pkg::RWPS_MODE_RECIRC);
        axi_wr(rwps_pkg::REG_CTRL1, 32'h0010_0000);
        rd_chk(rwps_pkg::REG_CTRL1, 32'h0010_0000);
        i_ctl.strobe();
        wait_addr(10'h004);
        chk(32'(sweep_over_flag), 32'h0);
        next_addr(10'h005);
        flag_cycles(2);
        next_addr(10'h008);
        next_addr(10'h009);
        chk(32'(gap), 32'h8);
        next_addr(10'h004);
        axi_wr(rwps_pkg::REG_CTRL1, 32'h0);
        // Recirculate on profile 0, then a pin change to profile 1
        prof(0, 10'h004, 10'h006, 16'h0007, rwps_pkg::RWPS_MODE_RECIRC);
        i_ctl.strobe();
        wait_addr(10'h004);
        next_addr(10'h005);
        next_addr(10'h006);
        chk(32'(gap), 32'h8);
        flag_cycles(2);
        next_addr(10'h004);
        repeat (3) @(posedge clk);
        chk(synth_out.word, {22'h0A5A5A, ram_addr});
        chk(32'(synth_out.dest), 32'(rwps_pkg::DEST_RST));
        i_ctl.set_pins(3'h1);
        wait_addr(10'h008);
        // Continuous bidirectional on profile 1
        prof(1, 10'h008, 10'h00A, 16'h0003, rwps_pkg::RWPS_MODE_CBIDIR);
        i_ctl.strobe();
        wait_addr(10'h008);
        next_addr(10'h009);
        next_addr(10'h00A);
        repeat (3) @(posedge clk);
        chk(32'(sweep_over_flag), 32'h1);
        next_addr(10'h009);
        next_addr(10'h008);
        repeat (3) @(posedge clk);
        chk(32'(sweep_over_flag), 32'h0);
        i_ctl.set_pins(3'h0);
        wait_addr(10'h004);
        // Bidirectional ramp steered by pin zero
        prof(0, 10'h004, 10'h006, 16'h000F, rwps_pkg::RWPS_MODE_BIDIR);
        i_ctl.strobe();
        wait_addr(10'h004);
        hold_chk(10'h004, 1'b0);
        i_ctl.set_pins(3'h1);
        wait_addr(10'h006);
        hold_chk(10'h006, 1'b1);
        i_ctl.set_pins(3'h0);
        next_addr(10'h005);
        wait_addr(10'h004);
        hold_chk(10'h004, 1'b1);
        i_ctl.set_pins(3'h6);
        hold_chk(10'h004, 1'b1);
        i_ctl.set_pins(3'h1);
        wait_addr(10'h005);
        chk(32'(sweep_over_flag), 32'h0);
        i_ctl.set_pins(3'h0);
        next_addr(10'h004);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule // rwps_seq_tb
`default_nettype wire
